/* File: logic/bfp_map.svh */
// Address map, field positions and timing constants of the bridge protection block
`ifndef BFP_MAP_SVH
`define BFP_MAP_SVH
`define BFP_CTRL_OFS     4'h0
`define BFP_STAT_OFS     4'h4
`define BFP_LATCH_BIT    0
`define BFP_RESP_OKAY    2'b00
`define BFP_RESP_DECERR  2'b11
`define BFP_CLK_NS       4
`define BFP_RECHARGE_NS  50
`define BFP_RECHARGE_CYC ((`BFP_RECHARGE_NS + `BFP_CLK_NS - 1) / `BFP_CLK_NS)
`define BFP_PERIOD_CYC   256
`define BFP_CTRL_RST     32'h0000_0000
`endif

/* File: logic/bfp_pkg.sv */
// Types shared by the bridge protection block
package bfp_pkg;
  typedef enum logic [1:0] {
    BFP_RUN     = 2'b00,
    BFP_LO_HOLD = 2'b01,
    BFP_HI_HOLD = 2'b11,
    BFP_SHUT    = 2'b10
  } bfp_state_t;

  typedef struct packed {
    logic [3:0] hs;
    logic [3:0] ls;
  } bfp_gate_t;

  typedef struct packed {
    logic       fault;
    logic       uvp;
    logic       warn;
    logic       therm;
    logic [3:0] hold;
    logic [3:0] shut;
  } bfp_status_t;
endpackage : bfp_pkg

/* File: logic/bfp_core.sv */
// Fault protection and status signalling for four half-bridges
//
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "bfp_map.svh"

module bfp_core #(
  parameter int unsigned PERIOD_CYC = `BFP_PERIOD_CYC
) (
  // Clock and reset
  input  wire  logic        mclk,
  input  wire  logic        nrst,
  // AXI4-Lite slave
  input  wire  logic [3:0]  s_axi_awaddr,
  input  wire  logic        s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire  logic [31:0] s_axi_wdata,
  input  wire  logic [3:0]  s_axi_wstrb,
  input  wire  logic        s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire  logic        s_axi_bready,
  input  wire  logic [3:0]  s_axi_araddr,
  input  wire  logic        s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire  logic        s_axi_rready,
  // Controller inputs
  input  wire  logic [3:0]  pwm_in,
  input  wire  logic        pair_one_reset_n,
  input  wire  logic        pair_two_reset_n,
  // Sensing
  input  wire  logic [3:0]  oc_high_side,
  input  wire  logic [3:0]  oc_low_side,
  input  wire  logic [3:0]  oc_uncontained,
  input  wire  logic [3:0]  boot_low,
  input  wire  logic        gate_supply_low,
  input  wire  logic        temp_warn,
  input  wire  logic        temp_shut,
  // Power stage
  output bfp_pkg::bfp_gate_t gate,
  output logic [3:0]        pulldown_en,
  // Open-drain status pins
  input  wire  logic        shutdown_fault_n_i,
  output logic              shutdown_fault_n_o,
  output logic              shutdown_fault_n_oe,
  input  wire  logic        heat_warning_n_i,
  output logic              heat_warning_n_o,
  output logic              heat_warning_n_oe
);

  bfp_pkg::bfp_state_t  st_reg [4];
  bfp_pkg::bfp_gate_t   gate_next;
  bfp_pkg::bfp_status_t stat;
  logic [31:0] ctrl_reg;
  logic [3:0]  pwm_reg;
  logic [1:0]  prst_reg;
  logic [1:0]  seen_reg;
  logic        therm_reg;
  logic [7:0]  rch_cnt_reg;
  logic        rch_win;
  logic        latch_mode;
  logic [3:0]  pwm_rise;
  logic [1:0]  pair_rise;
  logic [1:0]  pair_low;
  logic [3:0]  bridge_low;
  logic [3:0]  oc_any;
  logic        fault_cause;
  logic        aw_full_reg;
  logic        w_full_reg;
  logic [3:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;

  assign latch_mode = ctrl_reg[`BFP_LATCH_BIT];
  assign pwm_rise   = pwm_in & ~pwm_reg;
  assign pair_low   = {~pair_two_reset_n, ~pair_one_reset_n};
  assign pair_rise  = ~pair_low & prst_reg;
  assign bridge_low = {{2{pair_low[1]}}, {2{pair_low[0]}}};
  assign oc_any     = oc_high_side | oc_low_side;
  assign fault_cause = therm_reg || gate_supply_low || (|stat.shut);

  // Input history for edge detection
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pwm_reg  <= 4'h0;
      prst_reg <= 2'h0;
    end else begin
      pwm_reg  <= pwm_in;
      prst_reg <= pair_low;
    end
  end

  // Per-bridge protection state, each bridge on its own
  always_ff @(posedge mclk) begin
    for (int i = 0; i < 4; i++) begin
      if (!nrst) begin
        st_reg[i] <= bfp_pkg::BFP_RUN;
      end else begin
        case (st_reg[i])
          bfp_pkg::BFP_RUN: begin
            if (oc_uncontained[i] || (latch_mode && oc_any[i])) begin
              st_reg[i] <= bfp_pkg::BFP_SHUT;
            end else if (oc_low_side[i]) begin
              st_reg[i] <= bfp_pkg::BFP_LO_HOLD;
            end else if (oc_high_side[i]) begin
              st_reg[i] <= bfp_pkg::BFP_HI_HOLD;
            end
          end
          bfp_pkg::BFP_LO_HOLD, bfp_pkg::BFP_HI_HOLD: begin
            if (oc_uncontained[i]) begin
              st_reg[i] <= bfp_pkg::BFP_SHUT;
            end else if (pwm_rise[i]) begin
              st_reg[i] <= bfp_pkg::BFP_RUN;
            end
          end
          bfp_pkg::BFP_SHUT: begin
            if (pair_rise[i/2] && !oc_uncontained[i] && !(latch_mode && oc_any[i])) begin
              st_reg[i] <= bfp_pkg::BFP_RUN;
            end
          end
          default: st_reg[i] <= bfp_pkg::BFP_RUN;
        endcase
      end
    end
  end

  // Thermal latch; a new trip wins over a clear
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      therm_reg <= 1'b0;
      seen_reg  <= 2'b00;
    end else if (temp_shut) begin
      therm_reg <= 1'b1;
      seen_reg  <= 2'b00;
    end else if (therm_reg) begin
      if (&(seen_reg | pair_rise)) begin
        therm_reg <= 1'b0;
        seen_reg  <= 2'b00;
      end else begin
        seen_reg <= seen_reg | pair_rise;
      end
    end
  end

  // Recharge window divider: high side of a bridge with boot_low off for the recharge time each period
  always_ff @(posedge mclk) begin
    if (!nrst || rch_cnt_reg == 8'(PERIOD_CYC - 1)) begin
      rch_cnt_reg <= 8'h00;
    end else begin
      rch_cnt_reg <= rch_cnt_reg + 8'h01;
    end
  end
  assign rch_win = rch_cnt_reg < 8'(`BFP_RECHARGE_CYC);

  // Gate drive decision
  always_comb begin
    gate_next.hs = pwm_in;
    gate_next.ls = ~pwm_in;
    for (int i = 0; i < 4; i++) begin
      case (st_reg[i])
        bfp_pkg::BFP_LO_HOLD: begin
          gate_next.hs[i] = 1'b0;
          gate_next.ls[i] = 1'b0;
        end
        bfp_pkg::BFP_HI_HOLD: begin
          gate_next.hs[i] = 1'b0;
          gate_next.ls[i] = oc_high_side[i];
        end
        bfp_pkg::BFP_SHUT: begin
          gate_next.hs[i] = 1'b0;
          gate_next.ls[i] = 1'b0;
        end
        default: ;  // Running bridge keeps the plain drive set above
      endcase
      if (boot_low[i] && rch_win) begin
        gate_next.hs[i] = 1'b0;
      end
      if (bridge_low[i] || therm_reg || gate_supply_low) begin
        gate_next.hs[i] = 1'b0;
        gate_next.ls[i] = 1'b0;
      end
    end
  end

  // Registered stage and status outputs
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      gate                <= '0;
      pulldown_en         <= 4'h0;
      shutdown_fault_n_oe <= 1'b0;
      heat_warning_n_oe   <= 1'b0;
    end else begin
      gate                <= gate_next;
      pulldown_en         <= bridge_low;
      shutdown_fault_n_oe <= fault_cause;
      heat_warning_n_oe   <= temp_warn;
    end
  end
  assign shutdown_fault_n_o = 1'b0;
  assign heat_warning_n_o   = 1'b0;

  always_comb begin
    stat.fault = !shutdown_fault_n_i;
    stat.uvp   = gate_supply_low;
    stat.warn  = !heat_warning_n_i;
    stat.therm = therm_reg;
    for (int i = 0; i < 4; i++) begin
      stat.hold[i] = st_reg[i] == bfp_pkg::BFP_LO_HOLD || st_reg[i] == bfp_pkg::BFP_HI_HOLD;
      stat.shut[i] = st_reg[i] == bfp_pkg::BFP_SHUT;
    end
  end

  // AXI4-Lite write path: address and data taken in either order
  assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_full_reg && !s_axi_bvalid;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      aw_full_reg  <= 1'b0;
      w_full_reg   <= 1'b0;
      aw_addr_reg  <= 4'h0;
      w_data_reg   <= 32'h0000_0000;
      w_strb_reg   <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `BFP_RESP_OKAY;
      ctrl_reg     <= `BFP_CTRL_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (aw_full_reg && w_full_reg) begin
        aw_full_reg  <= 1'b0;
        w_full_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr_reg == `BFP_CTRL_OFS) begin
          s_axi_bresp <= `BFP_RESP_OKAY;
          if (w_strb_reg[`BFP_LATCH_BIT / 8]) begin
            ctrl_reg[`BFP_LATCH_BIT] <= w_data_reg[`BFP_LATCH_BIT];
          end
        end else if (aw_addr_reg == `BFP_STAT_OFS) begin
          s_axi_bresp <= `BFP_RESP_OKAY;
        end else begin
          s_axi_bresp <= `BFP_RESP_DECERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read path
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `BFP_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `BFP_RESP_OKAY;
      if (s_axi_araddr == `BFP_CTRL_OFS) begin
        s_axi_rdata <= ctrl_reg;
      end else if (s_axi_araddr == `BFP_STAT_OFS) begin
        s_axi_rdata <= {20'h00000, stat};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `BFP_RESP_DECERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  chk_fault_supply: assert property (gate_supply_low |=> shutdown_fault_n_oe)
    else $error("supply low did not pull fault");
  chk_warn_follows: assert property (temp_warn != heat_warning_n_oe |=> temp_warn == $past(temp_warn) |->
    heat_warning_n_oe == $past(temp_warn)) else $error("warning output wrong");
  chk_supply_hiz: assert property (gate_supply_low |=> gate == '0)
    else $error("outputs not off on supply low");
  chk_lo_hold: assert property (st_reg[0] == bfp_pkg::BFP_LO_HOLD && !pwm_rise[0] |=> !gate.hs[0] && !gate.ls[0])
    else $error("low-side hold drives bridge");
  chk_hi_hold: assert property (st_reg[1] == bfp_pkg::BFP_HI_HOLD && oc_high_side[1] && !pwm_rise[1]
    && !gate_supply_low && !therm_reg && pair_one_reset_n |=> !gate.hs[1] && gate.ls[1])
    else $error("high-side hold wrong");
  chk_hard_short: assert property (oc_uncontained[3] |=> st_reg[3] == bfp_pkg::BFP_SHUT)
    else $error("short not latched");
  chk_latch_mode: assert property (latch_mode && oc_low_side[2] |=> st_reg[2] == bfp_pkg::BFP_SHUT)
    else $error("latch mode did not shut");
  chk_therm_trip: assert property (temp_shut |=> therm_reg ##1 gate == '0 && shutdown_fault_n_oe)
    else $error("thermal trip incomplete");
  chk_therm_hold: assert property (therm_reg && !temp_shut && !(&(seen_reg | pair_rise)) |=> therm_reg)
    else $error("thermal latch dropped early");
  chk_pair_clear: assert property (st_reg[2] == bfp_pkg::BFP_SHUT && pair_rise[1] && !oc_any[2]
    && !oc_uncontained[2] |=> st_reg[2] == bfp_pkg::BFP_RUN)
    else $error("pair reset did not clear");
  chk_pair_off: assert property (!pair_two_reset_n |=> gate.hs[3:2] == 2'b00 && gate.ls[3:2] == 2'b00
    && pulldown_en[3:2] == 2'b11)
    else $error("pair reset did not force off");
  chk_clean_start: assert property ($rose(nrst) |-> !shutdown_fault_n_oe && !heat_warning_n_oe)
    else $error("status not released after reset");

endmodule : bfp_core

/* File: verif/bfp_ctrl_model.sv */
// Controller model: PWM source and pair reset pulser facing the protection block
`timescale 1ns/1ps

module bfp_ctrl_model #(
  parameter int unsigned WAIT_CYC = 20,
  parameter int unsigned LOW_CYC  = 8
) (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       nrst,
  // Commands from the bench
  input  wire logic       pwm_run,
  input  wire logic [1:0] rst_req,
  // Controller outputs
  output logic [3:0]      pwm_in,
  output logic            pair_one_reset_n,
  output logic            pair_two_reset_n
);
  logic [4:0] pwm_cnt_reg;
  logic [1:0] rst_sel_reg;
  logic [7:0] rst_cnt_reg;
  logic       rst_low;

  // A 32-cycle period keeps the low side on 64 ns per cycle
  always_ff @(posedge mclk) begin
    if (!nrst)
      pwm_cnt_reg <= 5'h00;
    else if (pwm_run)
      pwm_cnt_reg <= pwm_cnt_reg + 5'h01; // Stopped counter holds the input level
  end

  // Settle time, scaled down, then a low pulse that clears latches
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rst_sel_reg <= 2'h0;
      rst_cnt_reg <= 8'h00;
    end else if (rst_req != 2'h0) begin
      rst_sel_reg <= rst_req;
      rst_cnt_reg <= 8'(WAIT_CYC + LOW_CYC);
    end else if (rst_cnt_reg != 8'h00) begin
      rst_cnt_reg <= rst_cnt_reg - 8'h01;
    end
  end

  assign rst_low          = (rst_cnt_reg != 8'h00) && (rst_cnt_reg <= 8'(LOW_CYC));
  assign pwm_in           = {4{pwm_cnt_reg[4]}};
  assign pair_one_reset_n = !(rst_sel_reg[0] && rst_low);
  assign pair_two_reset_n = !(rst_sel_reg[1] && rst_low);
endmodule : bfp_ctrl_model

/* File: verif/tb_top.sv */
// Self-checking bench for the bridge protection block
`timescale 1ns/1ps
`include "bfp_map.svh"

module tb_top;
  logic        mclk, nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pwm_run;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb, pwm_in, pulldown_en;
  logic [3:0]  oc_high_side, oc_low_side, oc_uncontained, boot_low;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rst_req, rs;
  logic        pair_one_reset_n, pair_two_reset_n, gate_supply_low, temp_warn, temp_shut;
  logic        shutdown_fault_n_o, shutdown_fault_n_oe, heat_warning_n_o, heat_warning_n_oe;
  logic        fault_pin, warn_pin;
  int          miscompares, check_count;
  bfp_pkg::bfp_gate_t gate;

  // Open-drain pins with their pull-up
  assign fault_pin = shutdown_fault_n_oe ? shutdown_fault_n_o : 1'b1;
  assign warn_pin  = heat_warning_n_oe ? heat_warning_n_o : 1'b1;

  bfp_core #(.PERIOD_CYC(16)) dut (.mclk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pwm_in,
    .pair_one_reset_n, .pair_two_reset_n, .oc_high_side, .oc_low_side, .oc_uncontained, .boot_low,
    .gate_supply_low, .temp_warn, .temp_shut, .gate, .pulldown_en, .shutdown_fault_n_i(fault_pin),
    .shutdown_fault_n_o, .shutdown_fault_n_oe, .heat_warning_n_i(warn_pin), .heat_warning_n_o, .heat_warning_n_oe);

  bfp_ctrl_model ctrl (.mclk, .nrst, .pwm_run, .rst_req, .pwm_in, .pair_one_reset_n, .pair_two_reset_n);

  initial mclk = 1'b0;
  always #2 mclk = ~mclk;

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      miscompares++;
    end
  endtask : chk

  function automatic logic [1:0] br(input int i);
    return {gate.hs[i], gate.ls[i]};
  endfunction : br

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    logic aw_open;
    logic w_open;
    aw_open = 1'b1;
    w_open = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw_open || w_open) begin
      @(posedge mclk);
      if (aw_open && s_axi_awready) aw_open = 1'b0;
      if (w_open && s_axi_wready) w_open = 1'b0;
      s_axi_awvalid <= aw_open;
      s_axi_wvalid <= w_open;
    end
    while (!s_axi_bvalid) @(posedge mclk);
    s_axi_bready <= 1'b0;
    chk("bresp", `BFP_RESP_OKAY, s_axi_bresp);
    @(posedge mclk);
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge mclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge mclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge mclk);
  endtask : axi_rd

  task automatic pwm_rise;
    pwm_run <= 1'b1;
    do @(posedge mclk); while (pwm_in[0]);
    do @(posedge mclk); while (!pwm_in[0]);
    tick(4);
  endtask : pwm_rise

  task automatic hold_high;
    pwm_rise();
    pwm_run <= 1'b0;
  endtask : hold_high

  task automatic pair_reset(input logic [1:0] m);
    logic [3:0] pd;
    pd = {{2{m[1]}}, {2{m[0]}}};
    rst_req <= m;
    tick(1);
    rst_req <= 2'b00;
    tick(24);
    chk("pulldown", {28'h0, pd}, pulldown_en);
    chk("reset hi-z", 0, {gate.hs & pd, gate.ls & pd});
    tick(12);
  endtask : pair_reset

  task automatic t_reset;
    chk("fault idle", 1, fault_pin);
    chk("warn idle", 1, warn_pin);
    chk("pulldown idle", 0, pulldown_en);
    axi_rd(`BFP_CTRL_OFS, rd, rs);
    chk("mode idle", `BFP_CTRL_RST, rd);
    axi_rd(`BFP_STAT_OFS, rd, rs);
    chk("status idle", 0, rd);
    axi_rd(4'h8, rd, rs);
    chk("unmapped resp", `BFP_RESP_DECERR, rs);
    chk("unmapped data", 0, rd);
  endtask : t_reset

  task automatic t_cbc;
    hold_high();
    oc_low_side <= 4'h1;
    tick(1);
    oc_low_side <= 4'h0;
    tick(4);
    chk("low oc bridge", 0, br(0));
    chk("other bridge", 2'b10, br(1));
    tick(20);
    chk("held input", 0, br(0));
    pwm_rise();
    chk("low oc resume", 2'b10, br(0));
    hold_high();
    oc_high_side <= 4'h2;
    tick(4);
    chk("high oc bridge", 2'b01, br(1));
    oc_high_side <= 4'h0;
    tick(4);
    chk("high oc idle", 0, br(1));
    pwm_rise();
    chk("high oc resume", 2'b10, br(1));
  endtask : t_cbc

  task automatic t_latch;
    int b;
    for (int m = 1; m >= 0; m--) begin
      b = (m == 1) ? 2 : 3;
      axi_wr(`BFP_CTRL_OFS, 32'(m));
      axi_rd(`BFP_CTRL_OFS, rd, rs);
      chk("mode readback", 32'(m), rd);
      hold_high();
      oc_low_side <= (m == 1) ? 4'h4 : 4'h0;
      oc_uncontained <= (m == 1) ? 4'h0 : 4'h8;
      tick(1);
      oc_low_side <= 4'h0;
      oc_uncontained <= 4'h0;
      tick(4);
      chk("shut bridge", 0, br(b));
      chk("shut fault", 2'b01, {fault_pin, warn_pin});
      pwm_rise();
      chk("shut latched", 0, br(b));
      pair_reset(2'b10);
      chk("shut cleared", 1, fault_pin);
      pwm_rise();
      chk("shut resume", 2'b10, br(b));
    end
  endtask : t_latch

  task automatic t_supply;
    gate_supply_low <= 1'b1;
    tick(3);
    chk("uvp gate", 0, gate);
    chk("uvp pins", 2'b01, {fault_pin, warn_pin});
    axi_rd(`BFP_STAT_OFS, rd, rs);
    chk("uvp status", 32'h0c00, rd & 32'h0c00);
    gate_supply_low <= 1'b0;
    tick(3);
    chk("uvp clear", 1, fault_pin);
    pwm_rise();
    chk("uvp resume", 2'b10, br(0));
  endtask : t_supply

  task automatic t_thermal;
    temp_warn <= 1'b1;
    tick(3);
    chk("warn only", 2'b10, {fault_pin, warn_pin});
    temp_shut <= 1'b1;
    tick(1);
    temp_shut <= 1'b0;
    tick(4);
    chk("thermal gate", 0, gate);
    chk("thermal pins", 2'b00, {fault_pin, warn_pin});
    pair_reset(2'b01);
    chk("one pair", 0, fault_pin);
    pair_reset(2'b10);
    chk("both pairs", 1, fault_pin);
    temp_warn <= 1'b0;
    tick(3);
    chk("normal pins", 2'b11, {fault_pin, warn_pin});
  endtask : t_thermal

  task automatic t_boot;
    int n;
    n = 0;
    hold_high();
    boot_low <= 4'h8;
    tick(4);
    repeat (32) begin
      tick(1);
      if (gate.hs[3] === 1'b0) n++;
    end
    chk("recharge cycles", 2 * `BFP_RECHARGE_CYC, n);
    chk("other high side", 1, gate.hs[2]);
    boot_low <= 4'h0;
    tick(3);
    chk("recharge end", 2'b10, br(3));
  endtask : t_boot

  task automatic end_of_test;
    if (miscompares == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test

  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    end_of_test();
  end

  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = '0;
    {oc_high_side, oc_low_side, oc_uncontained, boot_low, rst_req} = '0;
    {gate_supply_low, temp_warn, temp_shut} = '0;
    pwm_run = 1'b1;
    miscompares = 0;
    check_count = 0;
    nrst = 1'b0;
    tick(4);
    nrst <= 1'b1;
    tick(1);
    t_reset();
    t_cbc();
    t_latch();
    t_supply();
    t_thermal();
    t_boot();
    end_of_test();
  end
endmodule : tb_top
